// >>> scm_pkg.sv
/*
  scm_pkg: constants, types and register map of the servo control mode selector.
  assumes: all users reference items as scm_pkg::name; 32-bit AXI4-Lite register bus.
*/
`default_nettype none

package scm_pkg;

  // register byte offsets
  localparam logic [3:0] OFS_MODE_SETTING = 4'h0;
  localparam logic [3:0] OFS_INPUT_CFG = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;

  // mode setting field
  localparam int MODE_SETTING_W = 3;
  localparam logic [2:0] MODE_SETTING_RST = 3'h1;
  localparam logic [2:0] SET_SPEED = 3'h0;
  localparam logic [2:0] SET_POSITION = 3'h1;
  localparam logic [2:0] SET_TORQUE = 3'h2;
  localparam logic [2:0] SET_TORQUE_SPEED = 3'h3;
  localparam logic [2:0] SET_SPEED_POSITION = 3'h4;
  localparam logic [2:0] SET_TORQUE_POSITION = 3'h5;
  localparam logic [2:0] SET_TRIPLE = 3'h6;

  // input configuration field positions
  localparam int CFG_FIRST_IDX_LSB = 0;
  localparam int CFG_SECOND_IDX_LSB = 4;
  localparam int CFG_FIRST_HIGH_BIT = 8;
  localparam int CFG_SECOND_HIGH_BIT = 9;
  localparam int CFG_FIRST_MAPPED_BIT = 10;
  localparam int CFG_SECOND_MAPPED_BIT = 11;
  localparam logic [11:0] INPUT_CFG_RST = 12'h000;

  // status field positions
  localparam int STS_MODE_LSB = 0;
  localparam int STS_SETTING_LSB = 4;
  localparam int STS_SERVO_ON_BIT = 8;
  localparam int STS_RUN_BIT = 9;
  localparam int STS_FIRST_BIT = 10;
  localparam int STS_SECOND_BIT = 11;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // control loop in use, gray coded speed -> position -> torque
  typedef enum logic [1:0] {
    SCM_MODE_SPEED = 2'h0,
    SCM_MODE_POSITION = 2'h1,
    SCM_MODE_TORQUE = 2'h3
  } scm_mode_t;

  localparam scm_mode_t MODE_RST = SCM_MODE_POSITION;

  // mapping of one mode-select function onto a terminal
  typedef struct packed {
    logic mapped;
    logic active_high;
    logic [3:0] index;
  } scm_map_t;

  typedef struct packed {
    scm_map_t second;
    scm_map_t first;
  } scm_input_cfg_t;

endpackage

`default_nettype wire

// >>> scm_sync.sv
/*
  scm_sync: two-stage synchroniser for a vector of independent level inputs.
  assumes: each bit is a slow level; no bus coherence between bits is needed.
*/
`timescale 1ns/1ns
`default_nettype none

module scm_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] async_in,
  output var logic [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_sync;

  always_comb begin
    nxt_meta = resetn ? async_in : '0;
    nxt_sync = resetn ? meta_ff : '0;
  end

  always_ff @(posedge clk) begin
    meta_ff <= nxt_meta;
    sync_out <= nxt_sync;
  end

endmodule

`default_nettype wire

// >>> scm_mode_selector.sv
/*
  scm_mode_selector: picks the control loop (speed, position, torque) of a servo drive
  from a stored mode setting and up to two mode-select digital input terminals.
  assumes: AXI4-Lite master on clk; terminals, servo-on and run levels are asynchronous;
  keypad writes arrive as single-cycle strobes on clk.
*/
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
// Behaviour
// - compound settings switch the active mode only with servo-on active and drive running.
// - setting 0 speed, 1 position, 2 torque; default 1; written at stop; acts immediately.
// - setting 2 always runs torque control and ignores the mode-select inputs.
// - settings 3,4,5 pick torque/speed, speed/position, torque/position by first input.
// - setting 6: first input gives position, else second gives speed, else torque.
// - setting is writable from keypad or software tool and enables compound modes.
`timescale 1ns/1ns
`default_nettype none

module scm_mode_selector #(
  parameter int TERM_NUM = 8,
  parameter int ADDR_W = 4
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [TERM_NUM-1:0] digital_input_terminal,
  input wire logic servo_on_cmd,
  input wire logic drive_run,
  input wire logic keypad_wr_valid,
  input wire logic [2:0] keypad_wr_value,
  output var scm_pkg::scm_mode_t active_mode,
  output var logic setting_rejected,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output var logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output var logic s_axi_wready,
  output var logic [1:0] s_axi_bresp,
  output var logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output var logic s_axi_arready,
  output var logic [31:0] s_axi_rdata,
  output var logic [1:0] s_axi_rresp,
  output var logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // synchronised pins
  logic [TERM_NUM+1:0] pins_sync;
  logic [TERM_NUM-1:0] term_sync;
  logic servo_on_sync;
  logic run_sync;

  scm_sync #(
    .W(TERM_NUM + 2)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in({drive_run, servo_on_cmd, digital_input_terminal}),
    .sync_out(pins_sync)
  );

  assign term_sync = pins_sync[TERM_NUM-1:0];
  assign servo_on_sync = pins_sync[TERM_NUM];
  assign run_sync = pins_sync[TERM_NUM+1];

  // configuration state
  logic [2:0] control_mode_setting_ff;
  logic [2:0] nxt_control_mode_setting;
  scm_pkg::scm_input_cfg_t input_cfg_ff;
  scm_pkg::scm_input_cfg_t nxt_input_cfg;
  logic setting_rejected_ff;
  logic nxt_setting_rejected;

  // bus state
  logic aw_have_ff;
  logic nxt_aw_have;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic [ADDR_W-1:0] nxt_aw_addr;
  logic w_have_ff;
  logic nxt_w_have;
  logic [31:0] w_data_ff;
  logic [31:0] nxt_w_data;
  logic [3:0] w_strb_ff;
  logic [3:0] nxt_w_strb;
  logic awready_ff;
  logic nxt_awready;
  logic wready_ff;
  logic nxt_wready;
  logic bvalid_ff;
  logic nxt_bvalid;
  logic [1:0] bresp_ff;
  logic [1:0] nxt_bresp;
  logic arready_ff;
  logic nxt_arready;
  logic rvalid_ff;
  logic nxt_rvalid;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [1:0] rresp_ff;
  logic [1:0] nxt_rresp;

  // mode state
  scm_pkg::scm_mode_t mode_ff;
  scm_pkg::scm_mode_t nxt_mode;

  // terminal value through its configured active logic
  function automatic logic select_level(input scm_pkg::scm_map_t map,
                                        input logic [TERM_NUM-1:0] term);
    logic lvl;
    lvl = 1'b0;
    for (int i = 0; i < TERM_NUM; i++) begin
      if (map.index == 4'(i)) begin
        lvl = term[i];
      end
    end
    return map.mapped & (lvl ~^ map.active_high);
  endfunction

  logic first_active;
  logic second_active;
  logic stopped;

  assign first_active = select_level(input_cfg_ff.first, term_sync);
  assign second_active = select_level(input_cfg_ff.second, term_sync);
  assign stopped = ~run_sync;

  // status word
  logic [31:0] status_word;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[scm_pkg::STS_MODE_LSB +: 2] = mode_ff;
    status_word[scm_pkg::STS_SETTING_LSB +: 3] = control_mode_setting_ff;
    status_word[scm_pkg::STS_SERVO_ON_BIT] = servo_on_sync;
    status_word[scm_pkg::STS_RUN_BIT] = run_sync;
    status_word[scm_pkg::STS_FIRST_BIT] = first_active;
    status_word[scm_pkg::STS_SECOND_BIT] = second_active;
  end

  // bus write, bus read and configuration next values
  logic do_write;
  logic set_legal;
  logic [2:0] bus_setting;

  always_comb begin
    nxt_aw_have = aw_have_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_have = w_have_ff;
    nxt_w_data = w_data_ff;
    nxt_w_strb = w_strb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_arready = arready_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    nxt_control_mode_setting = control_mode_setting_ff;
    nxt_input_cfg = input_cfg_ff;
    nxt_setting_rejected = setting_rejected_ff;
    bus_setting = w_data_ff[2:0];
    set_legal = (w_data_ff[31:3] == 29'h0000_0000) && (bus_setting <= scm_pkg::SET_TRIPLE);
    if (s_axi_awvalid && awready_ff) begin
      nxt_aw_have = 1'b1;
      nxt_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_ff) begin
      nxt_w_have = 1'b1;
      nxt_w_data = s_axi_wdata;
      nxt_w_strb = s_axi_wstrb;
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    do_write = aw_have_ff && w_have_ff && !bvalid_ff;
    if (keypad_wr_valid) begin
      if (stopped && keypad_wr_value <= scm_pkg::SET_TRIPLE) begin
        nxt_control_mode_setting = keypad_wr_value;
        nxt_setting_rejected = 1'b0;
      end else begin
        nxt_setting_rejected = 1'b1;
      end
    end
    if (do_write) begin
      nxt_aw_have = 1'b0;
      nxt_w_have = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = scm_pkg::RESP_OKAY;
      unique case (aw_addr_ff[3:0])
        scm_pkg::OFS_MODE_SETTING: begin
          if (w_strb_ff[0]) begin
            if (stopped && set_legal) begin
              nxt_control_mode_setting = bus_setting;
              nxt_setting_rejected = 1'b0;
            end else begin
              nxt_bresp = scm_pkg::RESP_SLVERR;
              nxt_setting_rejected = 1'b1;
            end
          end
        end
        scm_pkg::OFS_INPUT_CFG: begin
          if (w_strb_ff[0]) begin
            nxt_input_cfg.first.index = w_data_ff[scm_pkg::CFG_FIRST_IDX_LSB +: 4];
            nxt_input_cfg.second.index = w_data_ff[scm_pkg::CFG_SECOND_IDX_LSB +: 4];
          end
          if (w_strb_ff[1]) begin
            nxt_input_cfg.first.active_high = w_data_ff[scm_pkg::CFG_FIRST_HIGH_BIT];
            nxt_input_cfg.second.active_high = w_data_ff[scm_pkg::CFG_SECOND_HIGH_BIT];
            nxt_input_cfg.first.mapped = w_data_ff[scm_pkg::CFG_FIRST_MAPPED_BIT];
            nxt_input_cfg.second.mapped = w_data_ff[scm_pkg::CFG_SECOND_MAPPED_BIT];
          end
        end
        scm_pkg::OFS_STATUS: begin
          nxt_bresp = scm_pkg::RESP_SLVERR;
        end
        default: begin
          nxt_bresp = scm_pkg::RESP_SLVERR;
        end
      endcase
    end
    nxt_awready = !nxt_aw_have && !nxt_bvalid;
    nxt_wready = !nxt_w_have && !nxt_bvalid;
    if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
      nxt_arready = 1'b1;
    end
    if (s_axi_arvalid && arready_ff) begin
      nxt_arready = 1'b0;
      nxt_rvalid = 1'b1;
      nxt_rresp = scm_pkg::RESP_OKAY;
      unique case (s_axi_araddr[3:0])
        scm_pkg::OFS_MODE_SETTING: begin
          nxt_rdata = {29'h0000_0000, control_mode_setting_ff};
        end
        scm_pkg::OFS_INPUT_CFG: begin
          nxt_rdata = {20'h0_0000, input_cfg_ff.second.mapped, input_cfg_ff.first.mapped,
                       input_cfg_ff.second.active_high, input_cfg_ff.first.active_high,
                       input_cfg_ff.second.index, input_cfg_ff.first.index};
        end
        scm_pkg::OFS_STATUS: begin
          nxt_rdata = status_word;
        end
        default: begin
          nxt_rdata = 32'h0000_0000;
          nxt_rresp = scm_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (!resetn) begin
      nxt_aw_have = 1'b0;
      nxt_aw_addr = '0;
      nxt_w_have = 1'b0;
      nxt_w_data = 32'h0000_0000;
      nxt_w_strb = 4'h0;
      nxt_awready = 1'b0;
      nxt_wready = 1'b0;
      nxt_bvalid = 1'b0;
      nxt_bresp = scm_pkg::RESP_OKAY;
      nxt_arready = 1'b0;
      nxt_rvalid = 1'b0;
      nxt_rdata = 32'h0000_0000;
      nxt_rresp = scm_pkg::RESP_OKAY;
      nxt_control_mode_setting = scm_pkg::MODE_SETTING_RST;
      nxt_input_cfg = scm_pkg::INPUT_CFG_RST;
      nxt_setting_rejected = 1'b0;
    end else if (!arready_ff && !rvalid_ff) begin
      nxt_arready = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    aw_have_ff <= nxt_aw_have;
    aw_addr_ff <= nxt_aw_addr;
    w_have_ff <= nxt_w_have;
    w_data_ff <= nxt_w_data;
    w_strb_ff <= nxt_w_strb;
    awready_ff <= nxt_awready;
    wready_ff <= nxt_wready;
    bvalid_ff <= nxt_bvalid;
    bresp_ff <= nxt_bresp;
    arready_ff <= nxt_arready;
    rvalid_ff <= nxt_rvalid;
    rdata_ff <= nxt_rdata;
    rresp_ff <= nxt_rresp;
    control_mode_setting_ff <= nxt_control_mode_setting;
    input_cfg_ff <= nxt_input_cfg;
    setting_rejected_ff <= nxt_setting_rejected;
  end

  // control mode decode
  logic switch_ok;

  always_comb begin
    switch_ok = servo_on_sync && run_sync;
    nxt_mode = mode_ff;
    unique case (control_mode_setting_ff)
      scm_pkg::SET_SPEED: nxt_mode = scm_pkg::SCM_MODE_SPEED;
      scm_pkg::SET_POSITION: nxt_mode = scm_pkg::SCM_MODE_POSITION;
      scm_pkg::SET_TORQUE: nxt_mode = scm_pkg::SCM_MODE_TORQUE;
      scm_pkg::SET_TORQUE_SPEED: begin
        if (switch_ok) begin
          nxt_mode = first_active ? scm_pkg::SCM_MODE_SPEED : scm_pkg::SCM_MODE_TORQUE;
        end
      end
      scm_pkg::SET_SPEED_POSITION: begin
        if (switch_ok) begin
          nxt_mode = first_active ? scm_pkg::SCM_MODE_POSITION : scm_pkg::SCM_MODE_SPEED;
        end
      end
      scm_pkg::SET_TORQUE_POSITION: begin
        if (switch_ok) begin
          nxt_mode = first_active ? scm_pkg::SCM_MODE_POSITION : scm_pkg::SCM_MODE_TORQUE;
        end
      end
      scm_pkg::SET_TRIPLE: begin
        if (switch_ok) begin
          if (first_active) begin
            nxt_mode = scm_pkg::SCM_MODE_POSITION;
          end else if (second_active) begin
            nxt_mode = scm_pkg::SCM_MODE_SPEED;
          end else begin
            nxt_mode = scm_pkg::SCM_MODE_TORQUE;
          end
        end
      end
      default: nxt_mode = mode_ff;
    endcase
    if (!resetn) begin
      nxt_mode = scm_pkg::MODE_RST;
    end
  end

  always_ff @(posedge clk) begin
    mode_ff <= nxt_mode;
  end

  assign active_mode = mode_ff;
  assign setting_rejected = setting_rejected_ff;
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

endmodule

`default_nettype wire

// >>> scm_checker_assertions.sv
/*
  scm_checker: concurrent checks on the mode selector's ports.
  assumes: bound to scm_mode_selector; one clock clk, synchronous active-low resetn.
*/
`timescale 1ns/1ns
`default_nettype none
module scm_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic keypad_wr_valid,
  input wire logic [2:0] keypad_wr_value,
  input wire logic servo_on_cmd,
  input wire logic drive_run,
  input wire scm_pkg::scm_mode_t active_mode,
  input wire logic setting_rejected,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  chk_reset_state: assert property (@(posedge clk)
    !resetn |=> active_mode == scm_pkg::MODE_RST && !s_axi_bvalid && !s_axi_rvalid)
    else $error("state after reset wrong");
  chk_mode_code: assert property (@(posedge clk) disable iff (!resetn)
    active_mode != 2'h2)
    else $error("illegal mode code");
  chk_stop_hold: assert property (@(posedge clk) disable iff (!resetn)
    $changed(active_mode) && $past(resetn) && !$past(keypad_wr_valid, 2) && !$past(s_axi_bvalid)
    |-> $past(servo_on_cmd, 3) && $past(drive_run, 3))
    else $error("mode changed while stopped");
  chk_keypad_range: assert property (@(posedge clk) disable iff (!resetn)
    keypad_wr_valid && keypad_wr_value > 3'h6 |=> setting_rejected)
    else $error("out of range keypad value taken");
  chk_bresp_stable: assert property (@(posedge clk) disable iff (!resetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_rdata_stable: assert property (@(posedge clk) disable iff (!resetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_read_answer: assert property (@(posedge clk) disable iff (!resetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  chk_bad_read: assert property (@(posedge clk) disable iff (!resetn)
    s_axi_rvalid && s_axi_rresp == scm_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("refused read carries data");
  chk_write_taken: assert property (@(posedge clk) disable iff (!resetn)
    $rose(s_axi_bvalid) |-> !s_axi_awready && !s_axi_wready)
    else $error("response before write taken");
endmodule
bind scm_mode_selector scm_checker u_chk (.*);
`default_nettype wire

// >>> scm_host_model.sv
/*
  scm_host: host controller driving the select terminals, servo-on and run levels.
  assumes: first select on terminal 2 active high, second on terminal 5 active low;
  other terminals toggle every cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module scm_host (
  input wire logic clk,
  input wire logic m1_req,
  input wire logic m2_req,
  input wire logic son_req,
  input wire logic run_req,
  output var logic [7:0] digital_input_terminal,
  output var logic servo_on_cmd,
  output var logic drive_run
);
  initial begin
    digital_input_terminal = 8'h00;
    servo_on_cmd = 1'b0;
    drive_run = 1'b0;
  end
  always @(posedge clk) begin
    digital_input_terminal[7:6] <= ~digital_input_terminal[7:6];
    digital_input_terminal[5] <= ~m2_req;
    digital_input_terminal[4:3] <= ~digital_input_terminal[4:3];
    digital_input_terminal[2] <= m1_req;
    digital_input_terminal[1:0] <= ~digital_input_terminal[1:0];
    servo_on_cmd <= son_req;
    drive_run <= run_req;
  end
endmodule
`default_nettype wire

// >>> servo_control_mode_selector_tb.sv
/*
  servo_control_mode_selector_tb: self-checking bench of the mode selector.
  assumes: 50 MHz clk; host model drives terminals; bench is the AXI4-Lite master.
*/
`timescale 1ns/1ns
`default_nettype none
module servo_control_mode_selector_tb;
  typedef struct packed {
    logic [2:0] set;
    logic m1;
    logic m2;
    logic [1:0] exp;
  } scm_row_t;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic m1_req = 1'b0;
  logic m2_req = 1'b0;
  logic son_req = 1'b1;
  logic run_req = 1'b0;
  logic keypad_wr_valid = 1'b0;
  logic [2:0] keypad_wr_value = 3'h0;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [7:0] digital_input_terminal;
  logic servo_on_cmd;
  logic drive_run;
  scm_pkg::scm_mode_t active_mode;
  logic setting_rejected;
  logic s_axi_awready;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic [1:0] resp;
  logic [31:0] data;
  int failures = 0;
  int samples_checked = 0;
  scm_row_t rows [13] = '{'{3'h0, 1'b1, 1'b1, 2'h0}, '{3'h1, 1'b0, 1'b0, 2'h1},
    '{3'h2, 1'b1, 1'b1, 2'h3}, '{3'h3, 1'b0, 1'b0, 2'h3}, '{3'h3, 1'b1, 1'b0, 2'h0},
    '{3'h4, 1'b0, 1'b1, 2'h0}, '{3'h4, 1'b1, 1'b0, 2'h1}, '{3'h5, 1'b0, 1'b0, 2'h3},
    '{3'h5, 1'b1, 1'b1, 2'h1}, '{3'h6, 1'b0, 1'b0, 2'h3}, '{3'h6, 1'b0, 1'b1, 2'h0},
    '{3'h6, 1'b1, 1'b0, 2'h1}, '{3'h6, 1'b1, 1'b1, 2'h1}};
  always #10 clk = ~clk;
  scm_host u_host (.*);
  scm_mode_selector uut (.*);
  task automatic close_out;
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_mode(input scm_pkg::scm_mode_t got, input logic [1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t mode %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    r = 2'h3;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    @(posedge clk);
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    r = 2'h3;
    d = 32'h0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        r = s_axi_rresp;
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    @(posedge clk);
  endtask
  task automatic keypad(input logic [2:0] v);
    keypad_wr_value <= v;
    keypad_wr_valid <= 1'b1;
    @(posedge clk);
    keypad_wr_valid <= 1'b0;
    ticks(2);
  endtask
  initial begin
    #400000;
    failures++;
    close_out();
  end
  initial begin
    ticks(2);
    resetn <= 1'b1;
    ticks(2);
    axi_wr(scm_pkg::OFS_INPUT_CFG, 32'h00000D52, resp);
    for (int i = 0; i < 13; i++) begin
      run_req <= 1'b0;
      ticks(4);
      axi_wr(scm_pkg::OFS_MODE_SETTING, {29'h0, rows[i].set}, resp);
      cmp_word({30'h0, resp}, {30'h0, scm_pkg::RESP_OKAY});
      m1_req <= rows[i].m1;
      m2_req <= rows[i].m2;
      run_req <= 1'b1;
      ticks(6);
      cmp_mode(active_mode, rows[i].exp);
    end
    axi_wr(scm_pkg::OFS_MODE_SETTING, 32'h0, resp);
    cmp_word({30'h0, resp}, {30'h0, scm_pkg::RESP_SLVERR});
    axi_rd(scm_pkg::OFS_MODE_SETTING, data, resp);
    cmp_word(data, 32'h6);
    run_req <= 1'b0;
    ticks(4);
    m1_req <= 1'b0;
    m2_req <= 1'b0;
    ticks(6);
    cmp_mode(active_mode, 2'h1);
    run_req <= 1'b1;
    ticks(6);
    cmp_mode(active_mode, 2'h3);
    son_req <= 1'b0;
    m1_req <= 1'b1;
    ticks(6);
    cmp_mode(active_mode, 2'h3);
    son_req <= 1'b1;
    keypad(3'h0);
    cmp_word({31'h0, setting_rejected}, 32'h1);
    run_req <= 1'b0;
    ticks(4);
    keypad(3'h7);
    cmp_word({31'h0, setting_rejected}, 32'h1);
    keypad(3'h0);
    cmp_word({31'h0, setting_rejected}, 32'h0);
    cmp_mode(active_mode, 2'h0);
    axi_rd(4'hC, data, resp);
    cmp_word({resp, data[29:0]}, {scm_pkg::RESP_SLVERR, 30'h0});
    axi_wr(scm_pkg::OFS_STATUS, 32'h0, resp);
    cmp_word({30'h0, resp}, {30'h0, scm_pkg::RESP_SLVERR});
    resetn <= 1'b0;
    ticks(2);
    resetn <= 1'b1;
    ticks(2);
    cmp_mode(active_mode, 2'h1);
    axi_rd(scm_pkg::OFS_MODE_SETTING, data, resp);
    cmp_word(data, 32'h1);
    axi_rd(scm_pkg::OFS_INPUT_CFG, data, resp);
    cmp_word(data, 32'h0);
    axi_rd(scm_pkg::OFS_STATUS, data, resp);
    cmp_word(data, 32'h0000_0111);
    close_out();
  end
endmodule
`default_nettype wire
